// *** hdl/cmpev_top.sv ***
`default_nettype none
// Notes on behaviour
// - Raw result is one when positive input exceeds negative input.
// - Result is synchronised before the status bit, one to two cycles late.
// - Flag is set by hardware on the edge type the mode selects.
// - Request only while flag, local enable and global enable are all one.
// - Flag clears automatically when the handler vector is taken.
// - Writing one to the flag clears it; zero leaves it.
// - Local enable at zero suppresses the request whatever the flag.
// - Capture route on feeds comparator output to timer capture; off, no link.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Power-off bit powers comparator down; disable interrupts before changing.
// - Bandgap select replaces positive input with fixed reference.
// - Low two bits of pin disable register turn off pin input buffers.
// - A disabled pin's port read bit always returns zero.
// - Bits 7 to 2 of pin disable register read zero.
module cmpev_top
   import cmpev_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Processor interrupt side
   input wire logic global_irq_enable,
   input wire logic irq_vector_taken,
   output logic cmp_irq_request,
   // Analog core
   input wire logic cmp_raw_result,
   output logic cmp_power_off,
   output logic cmp_bandgap_select,
   // Timer capture front end
   output logic cmp_capture_route,
   output logic capture_input,
   // Comparator pins, digital side
   input wire logic cmp_positive_pin,
   input wire logic cmp_negative_pin,
   output logic pos_pin_input_off,
   output logic neg_pin_input_off,
   output logic pos_pin_read,
   output logic neg_pin_read
);
   // ****************************************
   // Register state
   // ****************************************
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [1:0] pin_dis;
   logic [1:0] next_pin_dis;
   logic [1:0] sync_cmp;
   logic [1:0] next_sync_cmp;
   logic [1:0] sync_pos;
   logic [1:0] next_sync_pos;
   logic [1:0] sync_neg;
   logic [1:0] next_sync_neg;
   logic cap_q;
   logic next_cap_q;
   logic [7:0] next_rdata;
   logic cmp_sync_output;
   logic cmp_irq_flag;
   logic cmp_irq_enable;
   logic wr_ctrl;
   logic wr_dis;

   cmpev_edge_if eif();

   cmpev_edge_detect u_edge (
      .clk(clk),
      .reset(reset),
      .eif(eif)
   );

   assign cmp_sync_output = sync_cmp[1];
   assign cmp_irq_flag = ctrl[CMPEV_FLAG_BIT];
   assign cmp_irq_enable = ctrl[CMPEV_IRQ_EN_BIT];
   assign eif.level = cmp_sync_output;
   assign eif.mode = {ctrl[CMPEV_MODE_HI_BIT], ctrl[CMPEV_MODE_LO_BIT]};
   assign wr_ctrl = reg_wr && (reg_addr == CMPEV_CTRL_OFFSET);
   assign wr_dis = reg_wr && (reg_addr == CMPEV_PIN_DIS_OFFSET);

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      // Raw result arrives from the analog core, high when positive exceeds negative
      next_sync_cmp = {sync_cmp[0], cmp_raw_result};
      next_sync_pos = {sync_pos[0], cmp_positive_pin};
      next_sync_neg = {sync_neg[0], cmp_negative_pin};
      next_ctrl = ctrl;
      next_pin_dis = pin_dis;
      if (wr_ctrl) begin
         next_ctrl[7:6] = reg_wdata[7:6];
         next_ctrl[3:0] = reg_wdata[3:0];
         if (reg_wdata[CMPEV_FLAG_BIT]) begin
            next_ctrl[CMPEV_FLAG_BIT] = 1'b0;
         end
      end
      if (irq_vector_taken) begin
         next_ctrl[CMPEV_FLAG_BIT] = 1'b0;
      end
      // Set beats any clear in the same cycle so no event is lost
      if (eif.event_hit) begin
         next_ctrl[CMPEV_FLAG_BIT] = 1'b1;
      end
      next_ctrl[CMPEV_SYNC_OUT_BIT] = 1'b0;
      if (wr_dis) begin
         next_pin_dis = reg_wdata[1:0];
      end
      next_cap_q = ctrl[CMPEV_CAPTURE_BIT] & cmp_sync_output;
      if (reg_rd && reg_addr == CMPEV_CTRL_OFFSET) begin
         next_rdata = {ctrl[7:6], cmp_sync_output, ctrl[4:0]};
      end else if (reg_rd && reg_addr == CMPEV_PIN_DIS_OFFSET) begin
         next_rdata = {6'h00, pin_dis} & CMPEV_PIN_DIS_MASK;
      end else begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= CMPEV_CTRL_RESET;
         pin_dis <= CMPEV_PIN_DIS_RESET[1:0];
         sync_cmp <= 2'h0;
         sync_pos <= 2'h0;
         sync_neg <= 2'h0;
         cap_q <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         ctrl <= next_ctrl;
         pin_dis <= next_pin_dis;
         sync_cmp <= next_sync_cmp;
         sync_pos <= next_sync_pos;
         sync_neg <= next_sync_neg;
         cap_q <= next_cap_q;
         reg_rdata <= next_rdata;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Global enable comes from same-clock processor logic, so no synchroniser
   assign cmp_irq_request = cmp_irq_flag & cmp_irq_enable & global_irq_enable;
   assign cmp_power_off = ctrl[CMPEV_POWER_OFF_BIT];
   assign cmp_bandgap_select = ctrl[CMPEV_BANDGAP_BIT];
   assign cmp_capture_route = ctrl[CMPEV_CAPTURE_BIT];
   // Timer does its own noise cancel and edge select on this level
   assign capture_input = cap_q;
   assign pos_pin_input_off = pin_dis[CMPEV_POS_OFF_BIT];
   assign neg_pin_input_off = pin_dis[CMPEV_NEG_OFF_BIT];
   assign pos_pin_read = sync_pos[1] & ~pin_dis[CMPEV_POS_OFF_BIT];
   assign neg_pin_read = sync_neg[1] & ~pin_dis[CMPEV_NEG_OFF_BIT];

   // ****************************************
   // Checks
   // ****************************************
   sequence s_raw_held;
      cmp_raw_result [*2];
   endsequence

   sequence s_out_rise;
      !cmp_sync_output ##1 cmp_sync_output;
   endsequence

   sequence s_out_fall;
      cmp_sync_output ##1 !cmp_sync_output;
   endsequence

   chk_sync_latency: assert property (@(posedge clk) disable iff (reset)
      s_raw_held |=> cmp_sync_output)
      else $error("sync output late");
   chk_flag_set: assert property (@(posedge clk) disable iff (reset)
      eif.event_hit |=> cmp_irq_flag)
      else $error("flag not set on event");
   chk_irq_gate: assert property (@(posedge clk) disable iff (reset)
      cmp_irq_request == (cmp_irq_flag && cmp_irq_enable && global_irq_enable))
      else $error("request without all enables");
   chk_vector_clear: assert property (@(posedge clk) disable iff (reset)
      irq_vector_taken && !eif.event_hit |=> !cmp_irq_flag)
      else $error("flag not cleared by vector");
   chk_write_clear: assert property (@(posedge clk) disable iff (reset)
      wr_ctrl && !reg_wdata[CMPEV_FLAG_BIT] && !irq_vector_taken
         |=> cmp_irq_flag == $past(cmp_irq_flag | eif.event_hit))
      else $error("zero write changed flag");
   chk_enable_off: assert property (@(posedge clk) disable iff (reset)
      wr_ctrl && !reg_wdata[CMPEV_IRQ_EN_BIT] |=> !cmp_irq_request)
      else $error("request while disabled");
   chk_capture_off: assert property (@(posedge clk) disable iff (reset)
      !cmp_capture_route [*2] |-> !capture_input)
      else $error("capture active while unrouted");
   chk_pin_read_zero: assert property (@(posedge clk) disable iff (reset)
      pos_pin_input_off |-> !pos_pin_read)
      else $error("disabled pin reads one");
   chk_dis_reserved: assert property (@(posedge clk) disable iff (reset)
      $past(reg_rd) && $past(reg_addr) == CMPEV_PIN_DIS_OFFSET |-> reg_rdata[7:2] == 6'h00)
      else $error("reserved bits read nonzero");
   // Edge checks reckon from the status bit alone, so a broken detector is caught
   chk_rise_flag: assert property (@(posedge clk) disable iff (reset)
      s_out_rise ##0 (eif.mode == CMPEV_MODE_RISE || eif.mode == CMPEV_MODE_TOGGLE)
         |=> cmp_irq_flag)
      else $error("rising edge missed");
   chk_fall_flag: assert property (@(posedge clk) disable iff (reset)
      s_out_fall ##0 (eif.mode == CMPEV_MODE_FALL || eif.mode == CMPEV_MODE_TOGGLE)
         |=> cmp_irq_flag)
      else $error("falling edge missed");
   chk_one_clear: assert property (@(posedge clk) disable iff (reset)
      wr_ctrl && reg_wdata[CMPEV_FLAG_BIT] && !eif.event_hit |=> !cmp_irq_flag)
      else $error("flag not cleared by write");
   chk_capture_on: assert property (@(posedge clk) disable iff (reset)
      cmp_capture_route && cmp_sync_output |=> capture_input)
      else $error("capture not following output");
   chk_neg_read_zero: assert property (@(posedge clk) disable iff (reset)
      neg_pin_input_off |-> !neg_pin_read)
      else $error("disabled negative pin reads one");
   chk_pin_dis_write: assert property (@(posedge clk) disable iff (reset)
      wr_dis |=> {6'h00, pin_dis} == ($past(reg_wdata) & CMPEV_PIN_DIS_MASK))
      else $error("pin disable write lost");
endmodule
`default_nettype wire

// *** pkg/cmpev_pkg.sv ***
`default_nettype none
package cmpev_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CMPEV_CTRL_OFFSET = 8'h50;
   localparam logic [7:0] CMPEV_PIN_DIS_OFFSET = 8'h7f;
   localparam logic [7:0] CMPEV_CTRL_RESET = 8'h00;
   localparam logic [7:0] CMPEV_PIN_DIS_RESET = 8'h00;
   // Control/status field positions
   localparam int CMPEV_POWER_OFF_BIT = 7;
   localparam int CMPEV_BANDGAP_BIT = 6;
   localparam int CMPEV_SYNC_OUT_BIT = 5;
   localparam int CMPEV_FLAG_BIT = 4;
   localparam int CMPEV_IRQ_EN_BIT = 3;
   localparam int CMPEV_CAPTURE_BIT = 2;
   localparam int CMPEV_MODE_HI_BIT = 1;
   localparam int CMPEV_MODE_LO_BIT = 0;
   // Pin disable field positions
   localparam int CMPEV_POS_OFF_BIT = 0;
   localparam int CMPEV_NEG_OFF_BIT = 1;
   localparam logic [7:0] CMPEV_PIN_DIS_MASK = 8'h03;
   // ****************************************
   // Interrupt modes
   // ****************************************
   localparam logic [1:0] CMPEV_MODE_TOGGLE = 2'h0;
   localparam logic [1:0] CMPEV_MODE_RSVD = 2'h1;
   localparam logic [1:0] CMPEV_MODE_FALL = 2'h2;
   localparam logic [1:0] CMPEV_MODE_RISE = 2'h3;
endpackage
`default_nettype wire

// *** pkg/cmpev_edge_if.sv ***
`default_nettype none
interface cmpev_edge_if;
   logic level;
   logic [1:0] mode;
   logic event_hit;
   modport ctrl (output level, output mode, input event_hit);
   modport det (input level, input mode, output event_hit);
endinterface
`default_nettype wire

// *** hdl/cmpev_edge_detect.sv ***
`default_nettype none
module cmpev_edge_detect
   import cmpev_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Level and mode in, event out
   cmpev_edge_if.det eif
);
   logic prev;
   logic next_prev;
   logic rise;
   logic fall;

   always_comb begin
      next_prev = eif.level;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   // Single-cycle event against previous clock value; reserved mode is silent
   always_comb begin
      rise = eif.level & ~prev;
      fall = ~eif.level & prev;
      case (eif.mode)
         CMPEV_MODE_TOGGLE: eif.event_hit = rise | fall;
         CMPEV_MODE_FALL: eif.event_hit = fall;
         CMPEV_MODE_RISE: eif.event_hit = rise;
         default: eif.event_hit = 1'b0;
      endcase
   end

   chk_reserved_silent: assert property (@(posedge clk) disable iff (reset)
      eif.mode == CMPEV_MODE_RSVD |-> !eif.event_hit)
      else $error("event in reserved mode");
endmodule
`default_nettype wire

// *** bench/cmpev_analog_model.sv ***
`default_nettype none
module cmpev_analog_model
#(
   // Reference level in millivolts; arbitrary plain default
   parameter int REF_MV = 500
)
(
   // Clock and reset for the timer front end
   input wire logic clk,
   input wire logic reset,
   // Analog levels in millivolts
   input wire logic [11:0] pos_mv,
   input wire logic [11:0] neg_mv,
   // Control from the block
   input wire logic power_off,
   input wire logic bandgap_select,
   // Result
   output logic raw_result,
   // Timer capture front end
   input wire logic capture_level,
   input wire logic timer_capture_irq_enable,
   output logic capture_irq_seen
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Comparison
   // ****************************************
   logic [11:0] pos_eff;
   assign pos_eff = bandgap_select ? 12'(REF_MV) : pos_mv;
   // Powered down core holds low so no edges leak out
   assign raw_result = !power_off && (pos_eff > neg_mv);
   // ****************************************
   // Timer capture front end
   // ****************************************
   logic capture_prev;
   // Sticky, so the bench may look at it any time after the edge
   always_ff @(posedge clk) begin
      if (reset) begin
         capture_prev <= 1'b0;
         capture_irq_seen <= 1'b0;
      end else begin
         capture_prev <= capture_level;
         if (timer_capture_irq_enable && capture_level && !capture_prev) begin
            capture_irq_seen <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** bench/cmpev_top_tb.sv ***
`default_nettype none
module cmpev_top_tb
   import cmpev_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset, reg_wr, reg_rd, gie, vec, irq, pwr, bg, route, cap, raw;
   logic pos_pin, neg_pin, pos_off, neg_off, pos_rd, neg_rd, fr, ff;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [11:0] pos_mv, neg_mv;
   logic [1:0] m;
   logic timer_capture_irq_enable, cap_irq;
   int n_mismatch, tests_run;
   cmpev_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .global_irq_enable(gie), .irq_vector_taken(vec), .cmp_irq_request(irq),
      .cmp_raw_result(raw), .cmp_power_off(pwr), .cmp_bandgap_select(bg),
      .cmp_capture_route(route), .capture_input(cap), .cmp_positive_pin(pos_pin),
      .cmp_negative_pin(neg_pin), .pos_pin_input_off(pos_off),
      .neg_pin_input_off(neg_off), .pos_pin_read(pos_rd), .neg_pin_read(neg_rd));
   cmpev_analog_model #(.REF_MV(32'h0000_0300)) core (.clk(clk), .reset(reset),
      .pos_mv(pos_mv), .neg_mv(neg_mv), .power_off(pwr), .bandgap_select(bg),
      .raw_result(raw), .capture_level(cap),
      .timer_capture_irq_enable(timer_capture_irq_enable), .capture_irq_seen(cap_irq));
   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      chk(name, exp, reg_rdata);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Whole run is under two hundred cycles; this leaves wide margin
   initial begin
      #20000;
      n_mismatch++;
      final_report();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {reset, reg_wr, reg_rd, gie, vec, pos_pin, neg_pin} = 7'h01 << 6;
      {reg_addr, reg_wdata} = 16'h0000;
      timer_capture_irq_enable = 1'b0;
      pos_mv = 12'h100;
      neg_mv = 12'h200;
      cyc(2);
      reset = 1'b0;
      rd(CMPEV_CTRL_OFFSET, CMPEV_CTRL_RESET, "ctrl reset");
      rd(CMPEV_PIN_DIS_OFFSET, CMPEV_PIN_DIS_RESET, "pin reset");
      wr(8'h51, 8'hff);
      rd(8'h51, 8'h00, "unmapped");
      rd(CMPEV_CTRL_OFFSET, 8'h00, "ctrl after unmapped");
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         fr = (m == CMPEV_MODE_TOGGLE) || (m == CMPEV_MODE_RISE);
         ff = (m == CMPEV_MODE_TOGGLE) || (m == CMPEV_MODE_FALL);
         wr(CMPEV_CTRL_OFFSET, {6'h00, m});
         wr(CMPEV_CTRL_OFFSET, {6'h04, m});
         pos_mv = 12'h300;
         cyc(4);
         rd(CMPEV_CTRL_OFFSET, {3'h1, fr, 2'h0, m}, "rise flag");
         wr(CMPEV_CTRL_OFFSET, {6'h04, m});
         pos_mv = 12'h100;
         cyc(4);
         rd(CMPEV_CTRL_OFFSET, {3'h0, ff, 2'h0, m}, "fall flag");
         wr(CMPEV_CTRL_OFFSET, {6'h04, m});
      end
      gie = 1'b1;
      wr(CMPEV_CTRL_OFFSET, 8'h03);
      wr(CMPEV_CTRL_OFFSET, 8'h1b);
      pos_mv = 12'h300;
      cyc(4);
      chk("irq all set", 8'h01, {7'h00, irq});
      gie = 1'b0;
      cyc(1);
      chk("irq global off", 8'h00, {7'h00, irq});
      gie = 1'b1;
      wr(CMPEV_CTRL_OFFSET, 8'h03);
      chk("irq local off", 8'h00, {7'h00, irq});
      rd(CMPEV_CTRL_OFFSET, 8'h33, "flag kept");
      wr(CMPEV_CTRL_OFFSET, 8'h0b);
      chk("irq again", 8'h01, {7'h00, irq});
      vec = 1'b1;
      cyc(1);
      vec = 1'b0;
      chk("irq after vector", 8'h00, {7'h00, irq});
      rd(CMPEV_CTRL_OFFSET, 8'h2b, "flag after vector");
      timer_capture_irq_enable = 1'b1;
      wr(CMPEV_CTRL_OFFSET, 8'h07);
      cyc(3);
      chk("capture on", 8'h07, {5'h00, route, cap, cap_irq});
      wr(CMPEV_CTRL_OFFSET, 8'h13);
      cyc(2);
      chk("capture off", 8'h00, {6'h00, route, cap});
      pos_mv = 12'h100;
      wr(CMPEV_CTRL_OFFSET, 8'h10);
      cyc(4);
      wr(CMPEV_CTRL_OFFSET, 8'h50);
      cyc(4);
      rd(CMPEV_CTRL_OFFSET, 8'h70, "bandgap");
      wr(CMPEV_CTRL_OFFSET, 8'hc0);
      cyc(4);
      rd(CMPEV_CTRL_OFFSET, 8'hd0, "power off");
      chk("analog outs", 8'h03, {6'h00, pwr, bg});
      wr(CMPEV_PIN_DIS_OFFSET, 8'hff);
      rd(CMPEV_PIN_DIS_OFFSET, 8'h03, "pin disable");
      {pos_pin, neg_pin} = 2'h3;
      cyc(4);
      chk("pins off", 8'h0c, {4'h0, pos_off, neg_off, pos_rd, neg_rd});
      wr(CMPEV_PIN_DIS_OFFSET, 8'h01);
      cyc(4);
      chk("pos off only", 8'h09, {4'h0, pos_off, neg_off, pos_rd, neg_rd});
      // Reset again mid-run: registers return to their reset values
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      rd(CMPEV_CTRL_OFFSET, CMPEV_CTRL_RESET, "ctrl after reset");
      rd(CMPEV_PIN_DIS_OFFSET, CMPEV_PIN_DIS_RESET, "pin after reset");
      chk("pins after reset", 8'h03, {4'h0, pos_off, neg_off, pos_rd, neg_rd});
      final_report();
   end
endmodule
`default_nettype wire
